/* cic_device.sv */
// Device end: init and clock configuration registers behind the serial
// port, PLL multiplier model, master clock and reference output divider.
// Assumes the link pins are synchronous to aclk; input_clock_tick carries the input clock level;
// input clock edge; lock is modelled from a relock count, not an analog input.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Multiplier field 1..31, resets to 8
// - Multiplier one bypasses PLL, uses input clock
// - Relock takes 200 master clock cycles
// - Host picks supported divider/multiplier pairs only
// - Reset bit restarts chip, reads zero
// - Soft reset keeps init register intact
// - Hardware reset pin restores all defaults
// - Bit 6 selects LSB-first serial order
// - Bit 7 selects three-wire shared data pin
// - Divider zero outputs buffered input clock
// - Divider 2..63 divides master clock
// - Master clock is system clock over 3/4
// - Lock mode drives lock on reference pin
// - Host writes zeros to fixed-zero bits
module cic_device (
   input  wire logic   aclk,
   input  wire logic   aresetn,
   cic_link_if.device  link,
   input  wire logic   input_clock_tick,
   input  wire logic   mclk_tick,
   output logic [4:0]  pll_multiplier,
   output logic        pll_bypass,
   output logic        pll_locked,
   output logic [2:0]  sys_divider,
   output logic        reference_output_pin,
   output logic        chip_restart
);
   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   logic [7:0] init_control;
   logic [7:0] clock_configuration;
   logic       sclk_q;
   logic [4:0] bit_cnt;
   logic [7:0] instr;
   logic [7:0] shift_in;
   logic [7:0] shift_out;
   logic [7:0] relock_cnt;
   logic [5:0] div_cnt;
   logic       div_clk;
   logic       rst_all;
   logic       soft_rst;
   logic       wr_strobe;
   logic       sample_bit;
   logic [7:0] rd_value;
   logic [7:0] wr_byte;

   assign rst_all    = !aresetn || !link.hw_reset_n;
   assign sample_bit = link.sdio;
   wire sclk_rise    = link.sclk && !sclk_q && !link.cs_n;
   wire sclk_fall    = !link.sclk && sclk_q && !link.cs_n;
   wire lsb_first    = init_control[cic_pkg::LSB_FIRST_BIT];
   wire three_wire   = init_control[cic_pkg::THREE_WIRE_BIT];

   // Reverse a byte for LSB-first transfers
   function automatic logic [7:0] cic_order(input logic [7:0] b, input logic lsb);
      cic_order = lsb ? {b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]} : b;
   endfunction

   // ----------------------------------------------------------------------
   // Serial port: instruction byte, then data byte
   // ----------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      sclk_q <= link.sclk;
   end

   always_ff @(posedge aclk) begin
      if (rst_all || link.cs_n) begin
         bit_cnt  <= 5'h00;
         shift_in <= 8'h00;
      end else if (sclk_rise) begin
         shift_in <= {shift_in[6:0], sample_bit};
         bit_cnt  <= bit_cnt + 5'h01;
      end
   end

   // Instruction captured once eight bits are in, order per bit 6
   always_ff @(posedge aclk) begin
      if (rst_all) begin
         instr <= 8'h00;
      end else if (sclk_rise && bit_cnt == 5'h07) begin
         instr <= cic_order({shift_in[6:0], sample_bit}, lsb_first);
      end
   end

   assign wr_byte   = cic_order({shift_in[6:0], sample_bit}, lsb_first);
   assign wr_strobe = sclk_rise && bit_cnt == 5'h0F && !instr[cic_pkg::INSTR_READ_BIT];

   always_comb begin
      case (instr[4:0])
         cic_pkg::INIT_CONTROL_ADDR: rd_value = init_control & cic_pkg::INIT_CONTROL_MASK;
         cic_pkg::CLOCK_CONFIG_ADDR: rd_value = clock_configuration;
         default:                    rd_value = 8'h00;
      endcase
   end

   // Read data shifted out on falling edges during the data byte
   always_ff @(posedge aclk) begin
      if (rst_all) begin
         shift_out <= 8'h00;
      end else if (sclk_rise && bit_cnt == 5'h07) begin
         shift_out <= 8'h00;
      end else if (sclk_fall && bit_cnt == 5'h08) begin
         shift_out <= cic_order(rd_value, lsb_first);
      end else if (sclk_fall && bit_cnt > 5'h08) begin
         shift_out <= {shift_out[6:0], 1'b0};
      end
   end

   // Drive either the shared pin or the separate output pin
   always_ff @(posedge aclk) begin
      if (rst_all) begin
         link.sdio_d_o            <= 1'b0;
         link.sdio_d_oe_n         <= 1'b1;
         link.serial_data_out_pin <= 1'b0;
      end else begin
         // Turn-around: take the pin after the host lets go, free it before cs_n rises
         link.sdio_d_oe_n <= !(three_wire && !link.cs_n && instr[cic_pkg::INSTR_READ_BIT]
                               && ((bit_cnt == 5'h08 && !link.sclk)
                                   || (bit_cnt > 5'h08 && bit_cnt < 5'h10)));
         link.sdio_d_o            <= shift_out[7];
         link.serial_data_out_pin <= three_wire ? 1'b0 : shift_out[7];
      end
   end

   // ----------------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------------
   assign soft_rst = wr_strobe && instr[4:0] == cic_pkg::INIT_CONTROL_ADDR
                     && wr_byte[cic_pkg::SOFT_RESET_BIT];

   // Init register: only the pin or bus reset restores it
   always_ff @(posedge aclk) begin
      if (rst_all) begin
         init_control <= cic_pkg::INIT_CONTROL_RESET;
      end else if (wr_strobe && instr[4:0] == cic_pkg::INIT_CONTROL_ADDR && !soft_rst) begin
         init_control <= wr_byte & cic_pkg::INIT_CONTROL_MASK;
      end
      // Soft reset leaves this register as it was
   end

   always_ff @(posedge aclk) begin
      if (rst_all || soft_rst) begin
         clock_configuration <= cic_pkg::CLOCK_CONFIG_RESET;
      end else if (wr_strobe && instr[4:0] == cic_pkg::CLOCK_CONFIG_ADDR) begin
         clock_configuration <= wr_byte;
      end
   end

   always_ff @(posedge aclk) begin
      chip_restart <= aresetn ? soft_rst : 1'b0;
   end

   // ----------------------------------------------------------------------
   // PLL model: multiplier, bypass and relock count
   // ----------------------------------------------------------------------
   wire [4:0] mult_field = init_control[cic_pkg::MULT_LSB +: cic_pkg::MULT_W];

   always_ff @(posedge aclk) begin
      if (rst_all) begin
         pll_multiplier <= cic_pkg::INIT_CONTROL_RESET[4:0];
         pll_bypass     <= 1'b0;
         sys_divider    <= 3'h4;
      end else begin
         // Zero is not a valid multiplier; hold the last legal value
         if (mult_field != 5'h00) begin
            pll_multiplier <= mult_field;
         end
         pll_bypass  <= mult_field == 5'h01;
         sys_divider <= cic_pkg::cic_sys_div(clock_configuration[cic_pkg::DIV3_BIT]);
      end
   end

   // Lock drops on any multiplier change, returns after 200 master cycles, or at once in bypass
   always_ff @(posedge aclk) begin
      if (rst_all || (mult_field != pll_multiplier && mult_field != 5'h00)) begin
         relock_cnt <= 8'h00;
         pll_locked <= 1'b0;
      end else if (pll_bypass) begin
         pll_locked <= 1'b1;
      end else if (mclk_tick && relock_cnt != 8'(cic_pkg::RELOCK_MCLK_CYCLES)) begin
         relock_cnt <= relock_cnt + 8'h01;
      end else if (relock_cnt == 8'(cic_pkg::RELOCK_MCLK_CYCLES)) begin
         pll_locked <= 1'b1;
      end
   end

   // ----------------------------------------------------------------------
   // Reference output: buffered input, divided master clock or lock flag
   // ----------------------------------------------------------------------
   wire [5:0] odiv = clock_configuration[cic_pkg::ODIV_LSB +: cic_pkg::ODIV_W];

   // Toggle every R/2 master ticks; odd R rounds the high phase up
   always_ff @(posedge aclk) begin
      if (rst_all || odiv < 6'h02) begin
         div_cnt <= 6'h00;
         div_clk <= 1'b0;
      end else if (mclk_tick) begin
         if (div_cnt == odiv - 6'h01) begin
            div_cnt <= 6'h00;
            div_clk <= 1'b0;
         end else begin
            div_cnt <= div_cnt + 6'h01;
            div_clk <= (div_cnt + 6'h01) >= (odiv >> 1);
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (rst_all) begin
         reference_output_pin <= 1'b0;
      end else if (clock_configuration[cic_pkg::LOCK_MODE_BIT]) begin
         reference_output_pin <= pll_locked;
      end else if (odiv < 6'h02) begin
         reference_output_pin <= input_clock_tick;
      end else begin
         reference_output_pin <= div_clk;
      end
   end
endmodule
`default_nettype wire

/* cic_host.sv */
// Host end: AXI4-Lite slave taking register commands and running the
// serial control link frames to the device.
// Assumes software respects supported divider/multiplier pairs.
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module cic_host (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   cic_link_if.host         link,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   typedef enum logic [2:0] {
      CIC_IDLE = 3'b001,
      CIC_SHIFT = 3'b010,
      CIC_DONE = 3'b100
   } cic_state_t;

   cic_state_t  state;
   logic [7:0]  aw_addr;
   logic        aw_full;
   logic [31:0] w_data;
   logic        w_full;
   logic [15:0] frame;
   logic [4:0]  bits_left;
   logic [2:0]  half_cnt;
   logic        is_read;
   logic [7:0]  rd_shift;
   logic [7:0]  read_data;
   logic [1:0]  fmt;    // [1] three-wire, [0] LSB first, mirrors device
   logic        hw_rst;

   wire start = aw_full && w_full && !s_axi_bvalid && state == CIC_IDLE
                && aw_addr == cic_pkg::HOST_CMD_OFFSET;
   wire half_end = half_cnt == 3'(cic_pkg::SCLK_HALF_CYCLES - 1);

   function automatic logic [7:0] cic_rev(input logic [7:0] b, input logic lsb);
      cic_rev = lsb ? {b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]} : b;
   endfunction

   // Instruction byte in wire order: read flag, fixed zeros, address
   wire [7:0] instr_byte = cic_rev({w_data[cic_pkg::CMD_READ_BIT], 2'b00, w_data[12:8]}, fmt[0]);

   // ----------------------------------------------------------------------
   // AXI write channels: address and data taken in either order
   // ----------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full <= 1'b0;
         w_full  <= 1'b0;
         aw_addr <= 8'h00;
         w_data  <= 32'h0000_0000;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= cic_pkg::AXI_OKAY;
         fmt     <= 2'h0;
         hw_rst  <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full <= 1'b1;
            w_data <= s_axi_wdata;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         // Command starts a frame; other offsets answer at once
         if (aw_full && w_full && !s_axi_bvalid && (state == CIC_IDLE || aw_addr != cic_pkg::HOST_CMD_OFFSET)) begin
            aw_full <= 1'b0;
            w_full  <= 1'b0;
            if (aw_addr != cic_pkg::HOST_CMD_OFFSET) begin
               s_axi_bvalid <= 1'b1;
               s_axi_bresp  <= (aw_addr == cic_pkg::HOST_FORMAT_OFFSET) ? cic_pkg::AXI_OKAY : cic_pkg::AXI_SLVERR;
               if (aw_addr == cic_pkg::HOST_FORMAT_OFFSET && s_axi_wstrb[0]) begin
                  fmt    <= w_data[1:0];
                  hw_rst <= w_data[2];
               end
            end
         end
         // Read commands answer here too; the byte is in place by the next read
         if (state == CIC_DONE) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= cic_pkg::AXI_OKAY;
         end
      end
   end

   assign s_axi_awready = !aw_full;
   assign s_axi_wready  = !w_full;

   // ----------------------------------------------------------------------
   // Serial frame engine
   // ----------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state     <= CIC_IDLE;
         frame     <= 16'h0000;
         bits_left <= 5'h00;
         half_cnt  <= 3'h0;
         is_read   <= 1'b0;
         rd_shift  <= 8'h00;
         read_data <= 8'h00;
         link.sclk <= 1'b0;
         link.cs_n <= 1'b1;
         link.sdio_h_o    <= 1'b0;
         link.sdio_h_oe_n <= 1'b1;
      end else begin
         case (state)
            CIC_IDLE: begin
               link.sdio_h_oe_n <= 1'b1;
               if (start) begin
                  is_read   <= w_data[cic_pkg::CMD_READ_BIT];
                  // Data field is the command's low byte as written; no fixed-zero masking
                  frame     <= {instr_byte,
                                cic_rev(w_data[7:0], fmt[0])};
                  bits_left <= 5'(cic_pkg::FRAME_BITS);
                  link.cs_n <= 1'b0;
                  link.sdio_h_oe_n <= 1'b0;
                  link.sdio_h_o    <= instr_byte[7];
                  half_cnt  <= 3'h0;
                  state     <= CIC_SHIFT;
               end
            end
            CIC_SHIFT: begin
               half_cnt <= half_end ? 3'h0 : half_cnt + 3'h1;
               if (half_end) begin
                  link.sclk <= !link.sclk;
                  if (link.sclk) begin
                     // Falling edge: present next bit or end the frame
                     frame     <= {frame[14:0], 1'b0};
                     bits_left <= bits_left - 5'h01;
                     link.sdio_h_o <= frame[14];
                     // Release shared pin for read data
                     link.sdio_h_oe_n <= is_read && fmt[1] && bits_left <= 5'h09;
                     if (bits_left == 5'h01) begin
                        link.cs_n <= 1'b1;
                        link.sdio_h_oe_n <= 1'b1;
                        state <= CIC_DONE;
                     end
                  end else if (bits_left <= 5'h08) begin
                     rd_shift <= {rd_shift[6:0], fmt[1] ? link.sdio : link.serial_data_out_pin};
                  end
               end
            end
            CIC_DONE: begin
               read_data <= cic_rev(rd_shift, fmt[0]);
               state     <= CIC_IDLE;
            end
            default: state <= CIC_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // AXI read channel
   // ----------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= cic_pkg::AXI_OKAY;
         link.hw_reset_n <= 1'b0;
      end else begin
         link.hw_reset_n <= !hw_rst;
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= cic_pkg::AXI_OKAY;
            case (s_axi_araddr)
               cic_pkg::HOST_STATUS_OFFSET: s_axi_rdata <= {31'h0, state != CIC_IDLE};
               cic_pkg::HOST_RDATA_OFFSET:  s_axi_rdata <= {24'h0, read_data};
               cic_pkg::HOST_FORMAT_OFFSET: s_axi_rdata <= {29'h0, hw_rst, fmt};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= cic_pkg::AXI_SLVERR;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

/* cic_link_if.sv */
// Serial control link between host controller and device.
// Assumes both ends run on the same clock; data pin resolved here.
`timescale 1ns/1ps
`default_nettype none
interface cic_link_if;
   logic sclk;       // Serial clock from host
   logic cs_n;       // Frame select, active low
   logic sdio_h_o;   // Host drive of shared data pin
   logic sdio_h_oe_n;// Host output enable, active low
   logic sdio_d_o;   // Device drive of shared data pin
   logic sdio_d_oe_n;// Device output enable, active low
   logic sdio;       // Resolved shared data level
   logic serial_data_out_pin; // Separate output pin (four-wire)
   logic hw_reset_n; // Hardware reset pin, active low

   // Pull-up when undriven; device wins if both drive
   assign sdio = !sdio_d_oe_n ? sdio_d_o : (!sdio_h_oe_n ? sdio_h_o : 1'b1);

   modport host (output sclk, output cs_n, output sdio_h_o, output sdio_h_oe_n,
                 input sdio, input serial_data_out_pin, output hw_reset_n);
   modport device (input sclk, input cs_n, output sdio_d_o, output sdio_d_oe_n,
                   input sdio, output serial_data_out_pin, input hw_reset_n);
endinterface
`default_nettype wire

/* cic_link_props.sv */
// Checker on the serial link joining the host and device ends.
// Assumes the bench places it beside the link, on the shared clock and reset.
`timescale 1ns/1ps
`default_nettype none
module cic_link_props (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdio_h_o,
   input wire logic sdio_h_oe_n,
   input wire logic sdio_d_oe_n,
   input wire logic hw_reset_n
);
   // -----------------------------------------------------------------
   // Framing and drive ownership
   // -----------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Serial clock rests low between frames
   AST_SCLK_IDLE: assert property (cs_n |-> !sclk) else $error("sclk moved outside a frame");
   // Each half period lasts four cycles
   AST_SCLK_HIGH: assert property ($rose(sclk) |-> sclk [*4]) else $error("sclk high phase short");
   AST_SCLK_LOW: assert property ($fell(sclk) && !cs_n |-> !sclk [*4]) else $error("sclk low phase short");
   // A frame holds cs_n low at least eight cycles and ends in bounded time
   AST_FRAME_LEN: assert property ($fell(cs_n) |-> !cs_n [*8] ##[1:300] cs_n) else $error("frame length wrong");
   // Host data must not move while the device may be sampling it
   AST_HOST_HOLD: assert property (sclk && $past(sclk) && !sdio_h_oe_n && !$past(sdio_h_oe_n)
      |-> $stable(sdio_h_o)) else $error("host data moved in high phase");
   // Shared pin is only driven inside a frame and never by both
   AST_HOST_DRV: assert property (!sdio_h_oe_n |-> !cs_n) else $error("host drives outside frame");
   AST_DEV_DRV: assert property (!sdio_d_oe_n |-> !cs_n) else $error("device drives outside frame");
   AST_NO_FIGHT: assert property (!(!sdio_h_oe_n && !sdio_d_oe_n)) else $error("both ends drive data");
   // Hardware reset pin still low on the first edge out of reset
   AST_HW_RESET: assert property ($rose(aresetn) |-> !hw_reset_n) else $error("hw reset released early");
   // Main scenarios reached
   cover property ($fell(cs_n));
   cover property (!sdio_d_oe_n);
   cover property ($rose(hw_reset_n));
endmodule
`default_nettype wire

/* cic_pkg.sv */
// Package for the clock and init configuration link: register map, fields,
// reset values, serial framing and timing counts.
// Assumes a single 100 MHz clock shared by both ends.
package cic_pkg;
   // ----------------------------------------------------------------------
   // Device register map
   // ----------------------------------------------------------------------
   localparam logic [4:0] INIT_CONTROL_ADDR     = 5'h00;
   localparam logic [4:0] CLOCK_CONFIG_ADDR     = 5'h01;
   localparam logic [7:0] INIT_CONTROL_RESET    = 8'h08;
   localparam logic [7:0] CLOCK_CONFIG_RESET    = 8'h00;
   // Init control fields
   localparam int         MULT_LSB              = 0;
   localparam int         MULT_W                = 5;
   localparam int         SOFT_RESET_BIT        = 5;
   localparam int         LSB_FIRST_BIT         = 6;
   localparam int         THREE_WIRE_BIT        = 7;
   // Clock configuration fields
   localparam int         ODIV_LSB              = 0;
   localparam int         ODIV_W                = 6;
   localparam int         DIV3_BIT              = 6;
   localparam int         LOCK_MODE_BIT         = 7;
   // Writable masks; other bits are fixed zero
   localparam logic [7:0] CLOCK_CONFIG_MASK     = 8'hFF;
   localparam logic [7:0] INIT_CONTROL_MASK     = 8'hDF;
   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam int         RELOCK_MCLK_CYCLES    = 200;
   localparam int         SCLK_HALF_CYCLES      = 4;
   localparam int         SCLK_HALF_W           = 3;
   // ----------------------------------------------------------------------
   // Host AXI4-Lite register offsets
   // ----------------------------------------------------------------------
   localparam logic [7:0] HOST_CMD_OFFSET       = 8'h00;
   localparam logic [7:0] HOST_STATUS_OFFSET    = 8'h04;
   localparam logic [7:0] HOST_RDATA_OFFSET     = 8'h08;
   localparam logic [7:0] HOST_FORMAT_OFFSET    = 8'h0C;
   // Command word: [7:0] data, [12:8] address, [16] read
   localparam int         CMD_READ_BIT          = 16;
   localparam logic [1:0] AXI_OKAY              = 2'h0;
   localparam logic [1:0] AXI_SLVERR            = 2'h2;
   // Serial frame length: one instruction byte, one data byte
   localparam int         FRAME_BITS            = 16;
   localparam int         INSTR_READ_BIT        = 7;
   // Master clock divider helper
   function automatic logic [2:0] cic_sys_div(input logic div3);
      cic_sys_div = div3 ? 3'h3 : 3'h4;
   endfunction
endpackage

/* clock_and_init_config_tb.sv */
// Bench: host and device ends joined by the link, software side over AXI4-Lite.
// Assumes one 100 MHz clock; input clock and master clock ticks are made here.
`timescale 1ns/1ps
`default_nettype none
module clock_and_init_config_tb;
   logic        aclk = 1'h0, aresetn = 1'h0, ict = 1'h0, mtk = 1'h0;
   logic [1:0]  cnt = 2'h0, bresp, rresp, rsp;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, rd_d;
   logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic        awready, wready, bvalid, arready, rvalid, byp, lock, refo, rst_p;
   logic [4:0]  mult;
   logic [2:0]  sdiv;
   int          err_count = 0, n_checks = 0, n, n_rst = 0;
   cic_link_if link ();
   cic_host u_cic_host (.aclk(aclk), .aresetn(aresetn), .link(link), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   cic_device u_cic_device (.aclk(aclk), .aresetn(aresetn), .link(link), .input_clock_tick(ict),
      .mclk_tick(mtk), .pll_multiplier(mult), .pll_bypass(byp), .pll_locked(lock), .sys_divider(sdiv),
      .reference_output_pin(refo), .chip_restart(rst_p));
   cic_link_props u_cic_link_props (.aclk(aclk), .aresetn(aresetn), .sclk(link.sclk), .cs_n(link.cs_n),
      .sdio_h_o(link.sdio_h_o), .sdio_h_oe_n(link.sdio_h_oe_n), .sdio_d_oe_n(link.sdio_d_oe_n),
      .hw_reset_n(link.hw_reset_n));
   // -----------------------------------------------------------------
   // Clock and tick sources
   // -----------------------------------------------------------------
   always #5 aclk = ~aclk;
   // Input clock period four cycles, master clock tick every fourth cycle, restarts counted
   always @(posedge aclk) begin
      n_rst <= n_rst + int'(rst_p === 1'h1);
      cnt <= cnt + 2'h1;
      mtk <= (cnt == 2'h3);
      ict <= cnt[1];
   end
   // -----------------------------------------------------------------
   // Tasks
   // -----------------------------------------------------------------
   task automatic end_sim;
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         $display("BAD %s expected %h seen %h", what, exp, got);
         err_count++;
      end
   endtask
   // One AXI4-Lite transfer; a frame write may keep the answer back for long
   task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      if (wr) begin
         awaddr  <= a;
         wdata   <= d;
         awvalid <= 1'h1;
         wvalid  <= 1'h1;
         bready  <= 1'h1;
      end else begin
         araddr  <= a;
         arvalid <= 1'h1;
         rready  <= 1'h1;
      end
      for (k = 0; k < 3000; k++) begin
         @(posedge aclk);
         if (wr && awready) awvalid <= 1'h0;
         if (wr && wready) wvalid <= 1'h0;
         if (!wr && arready) arvalid <= 1'h0;
         if (wr ? bvalid : rvalid) begin
            bready <= 1'h0;
            rready <= 1'h0;
            rsp = wr ? bresp : rresp;
            rd_d = rdata;
            break;
         end
      end
      // One idle edge so the next call never reassigns a strobe in this step
      @(posedge aclk);
      if (k == 3000) begin
         err_count++;
         end_sim();
      end
   endtask
   task automatic dev_wr(input logic [4:0] a, input logic [7:0] d);
      axi(1'h1, cic_pkg::HOST_CMD_OFFSET, {15'h0, 1'h0, 3'h0, a, d});
   endtask
   task automatic dev_rd(input logic [4:0] a, input logic [7:0] exp);
      axi(1'h1, cic_pkg::HOST_CMD_OFFSET, {15'h0, 1'h1, 3'h0, a, 8'h00});
      axi(1'h0, cic_pkg::HOST_RDATA_OFFSET, 32'h0);
      chk("device register", {24'h0, exp}, rd_d);
   endtask
   // Reference pin rising edges over 160 cycles
   task automatic rises(input int exp);
      logic p;
      p = refo;
      n = 0;
      repeat (160) begin
         @(posedge aclk);
         if (refo && !p) n++;
         p = refo;
      end
      chk("reference rises", 1, (n >= exp - 1 && n <= exp + 1));
   endtask
   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      dev_rd(5'h00, 8'h08);
      chk("multiplier", 5'h08, mult);
      chk("sys divider", 3'h4, sdiv);
      axi(1'h0, 8'h10, 32'h0);
      chk("unmapped resp", cic_pkg::AXI_SLVERR, rsp);
      rises(40);
      dev_wr(5'h01, 8'h01);
      rises(40);
      dev_wr(5'h01, 8'h02);
      rises(20);
      dev_wr(5'h01, 8'h42);
      chk("sys divider", 3'h3, sdiv);
      dev_rd(5'h01, 8'h42);
      dev_wr(5'h00, 8'h01);
      chk("bypass", 1'h1, byp);
      dev_wr(5'h00, 8'h0C);
      chk("lock dropped", 1'h0, lock);
      n = 0;
      while (lock !== 1'h1 && n < 1000) begin
         @(posedge aclk);
         n++;
      end
      chk("relock cycles", 1, (n >= 770 && n <= 810));
      chk("bypass", 1'h0, byp);
      dev_wr(5'h01, 8'h80);
      rises(0);
      chk("lock on pin", 1'h1, refo);
      dev_wr(5'h00, 8'h30);
      chk("restart pulses", 1, n_rst);
      dev_rd(5'h00, 8'h0C);
      dev_rd(5'h01, 8'h00);
      dev_wr(5'h00, 8'h50);
      axi(1'h1, cic_pkg::HOST_FORMAT_OFFSET, 32'h1);
      chk("format resp", cic_pkg::AXI_OKAY, rsp);
      dev_rd(5'h00, 8'h50);
      dev_wr(5'h00, 8'hD0);
      axi(1'h1, cic_pkg::HOST_FORMAT_OFFSET, 32'h3);
      dev_rd(5'h00, 8'hD0);
      axi(1'h1, cic_pkg::HOST_FORMAT_OFFSET, 32'h7);
      axi(1'h1, cic_pkg::HOST_FORMAT_OFFSET, 32'h0);
      dev_rd(5'h00, 8'h08);
      chk("multiplier", 5'h08, mult);
      end_sim();
   end
endmodule
`default_nettype wire
